// [common/swk_consts.svh]
// Functional notes
// - Wake-up key sequence holds at most six keys, leading from Doze to Active.
// - With the sequence enabled, stay in Doze until all keys match in order or a bus command arrives.
// - A wrong validated key discards progress; entry restarts at the first key.
// - A key counts only after touch then release; touch alone does not advance.
// - Complete correct sequence moves Doze to Active, never one stray activation.
// - With the sequence disabled, only a general input or bus command ends Doze.
// - Eight general pins each act as input, output or PWM output; inputs may wake.
`ifndef SWK_CONSTS_SVH
`define SWK_CONSTS_SVH
`define SWK_MAX_KEYS 6
`define SWK_KEY_W 3
`define SWK_POS_W 3
`define SWK_GPIO_N 8
`define SWK_PWM_W 8
`define SWK_MODE_W 2
`define SWK_MODE_IN 2'h0
`define SWK_MODE_OUT 2'h1
`define SWK_MODE_PWM 2'h2
`define SWK_POS_FIRST 3'h0
`endif

// [common/swk_pkg.sv]
`include "swk_consts.svh"
package swk_pkg;
   typedef enum logic {SWK_DOZE, SWK_ACTIVE} swk_power_t;
   // One touch or release key event from the button detection
   typedef struct packed
   {
      logic touch;
      logic release_ev;
      logic [`SWK_KEY_W-1:0] key;
   } swk_key_ev_t;
endpackage

// [rtl/swk_gpio_pin.sv]
`timescale 1ns/1ps
`default_nettype none
`include "swk_consts.svh"
module swk_gpio_pin
   import swk_pkg::*;
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [`SWK_MODE_W-1:0] mode_in,
   input wire logic out_level_in,
   input wire logic [`SWK_PWM_W-1:0] duty_in,
   input wire logic pin_in,
   input wire logic [`SWK_PWM_W-1:0] pwm_cnt_in,
   output logic pin_out,
   output logic pin_oe_n_out,
   output logic in_rise_out
);
   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic level_q;
   logic level_d;
   logic drv_q;
   logic drv_d;
   logic oe_n_q;
   logic oe_n_d;

   // Three-stage sampler; a change counts once stages two and three agree
   always_comb
   begin
      sync_d = {sync_q[1:0], pin_in};
      level_d = level_q;
      if (sync_q[1] == sync_q[2])
      begin
         level_d = sync_q[2];
      end
      drv_d = 1'b0;
      oe_n_d = 1'b1;
      unique case (mode_in)
         `SWK_MODE_OUT:
         begin
            drv_d = out_level_in;
            oe_n_d = 1'b0;
         end
         `SWK_MODE_PWM:
         begin
            drv_d = (pwm_cnt_in < duty_in);
            oe_n_d = 1'b0;
         end
         default:
         begin
            drv_d = 1'b0;
            oe_n_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         sync_q <= 3'h0;
         level_q <= 1'b0;
         drv_q <= 1'b0;
         oe_n_q <= 1'b1;
      end
      else
      begin
         sync_q <= sync_d;
         level_q <= level_d;
         drv_q <= drv_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign pin_out = drv_q;
   assign pin_oe_n_out = oe_n_q;
   // Wake only counts while the pin is an input
   assign in_rise_out = (mode_in == `SWK_MODE_IN) && level_d && !level_q;
endmodule
`default_nettype wire

// [rtl/swk_wake_seq.sv]
`timescale 1ns/1ps
`default_nettype none
`include "swk_consts.svh"
module swk_wake_seq
   import swk_pkg::*;
#(
   parameter int MAX_KEYS = `SWK_MAX_KEYS,
   parameter int GPIO_N = `SWK_GPIO_N
)
(
   input wire logic CORE_CLK_IN,
   input wire logic SRST_IN,
   input wire logic SEQ_ENABLE_IN,
   input wire logic [`SWK_POS_W-1:0] SEQ_LEN_IN,
   input wire logic [MAX_KEYS*`SWK_KEY_W-1:0] SEQ_KEYS_IN,
   input wire swk_key_ev_t KEY_EV_IN,
   input wire logic BUS_WAKE_IN,
   input wire logic SLEEP_REQ_IN,
   input wire logic [GPIO_N*`SWK_MODE_W-1:0] GPIO_MODE_IN,
   input wire logic [GPIO_N-1:0] GPIO_OUT_LEVEL_IN,
   input wire logic [GPIO_N*`SWK_PWM_W-1:0] GPIO_DUTY_IN,
   input wire logic [GPIO_N-1:0] GPIO_WAKE_EN_IN,
   input wire logic [GPIO_N-1:0] GPIO_PIN_IN,
   output logic [GPIO_N-1:0] GPIO_PIN_OUT,
   output logic [GPIO_N-1:0] GPIO_PIN_OE_N_OUT,
   output logic ACTIVE_OUT,
   output logic [`SWK_POS_W-1:0] SEQ_POS_OUT,
   output logic WAKE_EVENT_OUT
);
   ////////////////////////////////////////////////////////////////////////////
   // State
   swk_power_t power_q;
   swk_power_t power_d;
   logic [`SWK_POS_W-1:0] pos_q;
   logic [`SWK_POS_W-1:0] pos_d;
   logic armed_q;
   logic armed_d;
   logic [`SWK_KEY_W-1:0] armed_key_q;
   logic [`SWK_KEY_W-1:0] armed_key_d;
   logic [`SWK_PWM_W-1:0] pwm_cnt_q;
   logic [`SWK_PWM_W-1:0] pwm_cnt_d;
   logic wake_q;
   logic wake_d;
   logic [GPIO_N-1:0] gpio_rise;
   logic valid_key;
   logic [`SWK_KEY_W-1:0] expected_key;
   logic seq_done;
   logic gpio_wake;
   logic key_match;

   // Expected key at a given position
   function automatic logic [`SWK_KEY_W-1:0] key_at(input logic [`SWK_POS_W-1:0] p);
      key_at = SEQ_KEYS_IN[p*`SWK_KEY_W +: `SWK_KEY_W];
   endfunction

   // Last position of the sequence; a zero or oversize length could never complete,
   // so it is clamped into the slots that exist
   function automatic logic [`SWK_POS_W-1:0] last_pos(input logic [`SWK_POS_W-1:0] len);
      logic [`SWK_POS_W-1:0] n;
      n = len;
      if (len == `SWK_POS_FIRST)
      begin
         n = `SWK_POS_W'(1);
      end
      else if (len > `SWK_POS_W'(MAX_KEYS))
      begin
         n = `SWK_POS_W'(MAX_KEYS);
      end
      last_pos = n - `SWK_POS_W'(1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // General-purpose pins
   genvar g;
   generate
      for (g = 0; g < GPIO_N; g++)
      begin : gen_pin
         swk_gpio_pin u_pin
         (
            .clk_in(CORE_CLK_IN),
            .srst_in(SRST_IN),
            .mode_in(GPIO_MODE_IN[g*`SWK_MODE_W +: `SWK_MODE_W]),
            .out_level_in(GPIO_OUT_LEVEL_IN[g]),
            .duty_in(GPIO_DUTY_IN[g*`SWK_PWM_W +: `SWK_PWM_W]),
            .pin_in(GPIO_PIN_IN[g]),
            .pwm_cnt_in(pwm_cnt_q),
            .pin_out(GPIO_PIN_OUT[g]),
            .pin_oe_n_out(GPIO_PIN_OE_N_OUT[g]),
            .in_rise_out(gpio_rise[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Shared PWM counter; one count for all pins keeps them in phase, traded against
   // any per-pin phase offset
   always_comb
   begin
      pwm_cnt_d = pwm_cnt_q + `SWK_PWM_W'(1);
   end

   // PWM counter register
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (SRST_IN)
      begin
         pwm_cnt_q <= `SWK_PWM_W'(0);
      end
      else
      begin
         pwm_cnt_q <= pwm_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Key validation: a touch arms its key and only the matching release validates it,
   // so a sensor that never lets go can never move the sequence on
   always_comb
   begin
      armed_d = armed_q;
      armed_key_d = armed_key_q;
      valid_key = 1'b0;
      if (KEY_EV_IN.touch)
      begin
         armed_d = 1'b1;
         armed_key_d = KEY_EV_IN.key;
      end
      else if (KEY_EV_IN.release_ev && armed_q && (KEY_EV_IN.key == armed_key_q))
      begin
         valid_key = 1'b1;
         armed_d = 1'b0;
      end
      // A touch still armed from Active must not count in the next Doze
      if ((power_q == SWK_ACTIVE) && SLEEP_REQ_IN)
      begin
         armed_d = 1'b0;
      end
   end

   // Armed key registers
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (SRST_IN)
      begin
         armed_q <= 1'b0;
         armed_key_q <= `SWK_KEY_W'(0);
      end
      else
      begin
         armed_q <= armed_d;
         armed_key_q <= armed_key_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequence matching and power mode
   always_comb
   begin
      pos_d = pos_q;
      power_d = power_q;
      wake_d = 1'b0;
      expected_key = key_at(pos_q);
      gpio_wake = |(gpio_rise & GPIO_WAKE_EN_IN);
      key_match = valid_key && (KEY_EV_IN.key == expected_key);
      // The last key of the sequence completes it instead of advancing
      seq_done = key_match && (pos_q >= last_pos(SEQ_LEN_IN));
      unique case (power_q)
         SWK_DOZE:
         begin
            if (SEQ_ENABLE_IN)
            begin
               // Bus command still wakes; pin rises are ignored while the keys guard Doze
               if (seq_done || BUS_WAKE_IN)
               begin
                  power_d = SWK_ACTIVE;
                  wake_d = 1'b1;
               end
               else if (key_match)
               begin
                  pos_d = pos_q + `SWK_POS_W'(1);
               end
               else if (valid_key)
               begin
                  // Not retried as the first key: a stray press always costs a full restart
                  pos_d = `SWK_POS_FIRST;
               end
               else
               begin
                  pos_d = pos_q;
               end
            end
            else if (gpio_wake || BUS_WAKE_IN)
            begin
               power_d = SWK_ACTIVE;
               wake_d = 1'b1;
            end
         end
         SWK_ACTIVE:
         begin
            if (SLEEP_REQ_IN)
            begin
               power_d = SWK_DOZE;
               pos_d = `SWK_POS_FIRST;
            end
         end
      endcase
   end

   // Registers; reset lands in Doze with matching at its first key
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (SRST_IN)
      begin
         power_q <= SWK_DOZE;
         pos_q <= `SWK_POS_FIRST;
         wake_q <= 1'b0;
      end
      else
      begin
         power_q <= power_d;
         pos_q <= pos_d;
         wake_q <= wake_d;
      end
   end

   assign ACTIVE_OUT = (power_q == SWK_ACTIVE);
   assign SEQ_POS_OUT = pos_q;
   assign WAKE_EVENT_OUT = wake_q;
endmodule
`default_nettype wire

// [tb/swk_key_src.sv]
`timescale 1ns/1ps
`default_nettype none
module swk_key_src
   import swk_pkg::*;
(
   input wire logic clk_in,
   output var swk_key_ev_t ev_out
);
   initial ev_out = '0;
   // Touch then release; a stuck sensor never releases, so the code flips instead
   task automatic hit(input logic [2:0] k, input logic rel);
      @(negedge clk_in);
      ev_out <= '{1'b1, 1'b0, k};
      @(negedge clk_in);
      ev_out <= '{1'b0, rel, rel ? k : ~k};
      @(negedge clk_in);
      ev_out <= '{1'b0, 1'b0, ~k};
   endtask
endmodule
`default_nettype wire

// [tb/swk_wake_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "swk_consts.svh"
module swk_wake_properties
   import swk_pkg::*;
#(
   parameter int MAX_KEYS = 6,
   parameter int GPIO_N = 8
)
(
   input wire logic CORE_CLK_IN,
   input wire logic SRST_IN,
   input wire logic SEQ_ENABLE_IN,
   input wire swk_key_ev_t KEY_EV_IN,
   input wire logic BUS_WAKE_IN,
   input wire logic SLEEP_REQ_IN,
   input wire logic [GPIO_N-1:0] GPIO_WAKE_EN_IN,
   input wire logic ACTIVE_OUT,
   input wire logic [`SWK_POS_W-1:0] SEQ_POS_OUT,
   input wire logic WAKE_EVENT_OUT
);
   // All checks share the core clock and drop out during reset
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (SRST_IN);
   wake_pulse_a: assert property (WAKE_EVENT_OUT |=> !WAKE_EVENT_OUT)
      else $error("wake pulse too long");
   wake_rise_a: assert property ($rose(ACTIVE_OUT) |-> WAKE_EVENT_OUT)
      else $error("active without wake pulse");
   seq_hold_a:
      assert property (SEQ_ENABLE_IN && !ACTIVE_OUT && !KEY_EV_IN.release_ev && !BUS_WAKE_IN
         |=> !ACTIVE_OUT) else $error("left doze without release");
   pos_hold_a:
      assert property (!ACTIVE_OUT && !KEY_EV_IN.release_ev && !BUS_WAKE_IN && !SLEEP_REQ_IN
         |=> $stable(SEQ_POS_OUT)) else $error("position moved without release");
   pos_step_a:
      assert property (!ACTIVE_OUT |=> SEQ_POS_OUT == 3'h0 || $stable(SEQ_POS_OUT)
         || SEQ_POS_OUT == $past(SEQ_POS_OUT) + 3'h1) else $error("position jumped");
   pos_max_a: assert property (SEQ_POS_OUT <= 3'h6)
      else $error("position beyond six keys");
   bus_wake_a:
      assert property (BUS_WAKE_IN && !ACTIVE_OUT && !SLEEP_REQ_IN
         |=> ACTIVE_OUT && WAKE_EVENT_OUT) else $error("bus wake ignored");
   gpio_off_a:
      assert property (!SEQ_ENABLE_IN && !ACTIVE_OUT && !BUS_WAKE_IN && GPIO_WAKE_EN_IN == '0
         |=> !ACTIVE_OUT) else $error("doze left without a wake source");
   active_hold_a: assert property (ACTIVE_OUT && !SLEEP_REQ_IN |=> ACTIVE_OUT)
      else $error("active dropped without sleep");
   // Main scenarios reached
   cover property (WAKE_EVENT_OUT && SEQ_ENABLE_IN);
   cover property (WAKE_EVENT_OUT && !SEQ_ENABLE_IN);
   cover property (SEQ_POS_OUT == 3'h5);
   cover property (!ACTIVE_OUT && $past(SEQ_POS_OUT) != 3'h0 && SEQ_POS_OUT == 3'h0);
endmodule
bind swk_wake_seq swk_wake_properties #(.MAX_KEYS(MAX_KEYS), .GPIO_N(GPIO_N)) prop_u (
   .CORE_CLK_IN, .SRST_IN, .SEQ_ENABLE_IN, .KEY_EV_IN, .BUS_WAKE_IN, .SLEEP_REQ_IN,
   .GPIO_WAKE_EN_IN, .ACTIVE_OUT, .SEQ_POS_OUT, .WAKE_EVENT_OUT);
`default_nettype wire

// [tb/swk_wake_seq_test.sv]
`timescale 1ns/1ps
`default_nettype none
module swk_wake_seq_test;
   import swk_pkg::*;
   logic clk, rst, en, bus, slp, act, wake;
   logic [2:0] len, pos;
   logic [17:0] keys;
   logic [15:0] mode;
   logic [7:0] lvl, wen, pin, pout, poe;
   logic [63:0] duty;
   swk_key_ev_t ev;
   int n_errors, check_count;
   swk_wake_seq dut_u (.CORE_CLK_IN(clk), .SRST_IN(rst), .SEQ_ENABLE_IN(en),
      .SEQ_LEN_IN(len), .SEQ_KEYS_IN(keys), .KEY_EV_IN(ev), .BUS_WAKE_IN(bus),
      .SLEEP_REQ_IN(slp), .GPIO_MODE_IN(mode), .GPIO_OUT_LEVEL_IN(lvl),
      .GPIO_DUTY_IN(duty), .GPIO_WAKE_EN_IN(wen), .GPIO_PIN_IN(pin),
      .GPIO_PIN_OUT(pout), .GPIO_PIN_OE_N_OUT(poe), .ACTIVE_OUT(act),
      .SEQ_POS_OUT(pos), .WAKE_EVENT_OUT(wake));
   swk_key_src key_u (.clk_in(clk), .ev_out(ev));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Sleep pulse brings the block back to doze for the next scenario
   task automatic doze();
      @(negedge clk);
      slp = 1'b1;
      @(negedge clk);
      slp = 1'b0;
      chk("doze pos", pos, 8'h00);
      chk("doze act", act, 8'h00);
   endtask
   // Reset leaves Doze at the first key with every pin released
   task automatic s_reset();
      chk("reset act", act, 8'h00);
      chk("reset pos", pos, 8'h00);
      chk("reset oe", poe, 8'hFF);
      chk("reset wake", wake, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic s_order();
      len = 3'h3;
      key_u.hit(3'h1, 1'b1);
      chk("pos", pos, 8'h01);
      key_u.hit(3'h2, 1'b1);
      chk("early", act, 1'b0);
      key_u.hit(3'h3, 1'b1);
      chk("act", act, 1'b1);
      chk("wake", wake, 1'b1);
      doze();
   endtask
   // Wrong key drops back to the first key; touch alone never counts
   task automatic s_wrong();
      key_u.hit(3'h1, 1'b1);
      key_u.hit(3'h5, 1'b1);
      chk("wrong", pos, 8'h00);
      key_u.hit(3'h2, 1'b1);
      chk("restart", pos, 8'h00);
      key_u.hit(3'h1, 1'b0);
      chk("touch", pos, 8'h00);
      key_u.hit(3'h1, 1'b1);
      key_u.hit(3'h2, 1'b1);
      key_u.hit(3'h3, 1'b0);
      chk("held", act, 1'b0);
      key_u.hit(3'h3, 1'b1);
      chk("late", act, 1'b1);
      doze();
   endtask
   task automatic s_six();
      int i;
      len = 3'h6;
      for (i = 1; i < 6; i++)
         key_u.hit(i[2:0], 1'b1);
      chk("five", pos, 8'h05);
      key_u.hit(3'h6, 1'b1);
      chk("six", act, 1'b1);
      doze();
   endtask
   task automatic s_off();
      int i;
      wen = 8'h08;
      pin = 8'h08;
      repeat (10) @(negedge clk);
      chk("pin seq on", act, 1'b0);
      pin = 8'h00;
      en = 1'b0;
      wen = 8'h00;
      repeat (6) @(negedge clk);
      key_u.hit(3'h1, 1'b1);
      key_u.hit(3'h2, 1'b1);
      key_u.hit(3'h3, 1'b1);
      chk("keys off", act, 1'b0);
      bus = 1'b1;
      @(negedge clk);
      bus = 1'b0;
      chk("bus", act, 1'b1);
      doze();
      wen = 8'h08;
      pin = 8'h08;
      for (i = 0; i < 12 && act !== 1'b1; i++)
         @(negedge clk);
      chk("pin wake", act, 1'b1);
      if (act === 1'b1)
      begin
         wen = 8'h00;
         doze();
      end
      else
         complete_run();
   endtask
   // Pin 0 output high, pin 1 PWM at zero then half duty, pin 2 off, the rest inputs
   task automatic s_pins();
      int n_hi;
      mode = 16'h0039;
      lvl = 8'h01;
      repeat (3) @(negedge clk);
      chk("oe", poe, 8'hFC);
      chk("drive", pout & 8'h03, 8'h01);
      duty = 64'h0000_0000_0000_8000;
      n_hi = 0;
      repeat (256)
      begin
         @(negedge clk);
         n_hi += pout[1];
      end
      chk("pwm duty", 8'(n_hi), 8'h80);
      // Mid-run reset from Active must release every pin and return to Doze
      bus = 1'b1;
      @(negedge clk);
      bus = 1'b0;
      chk("bus again", act, 1'b1);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      s_reset();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      {rst, en, bus, slp} = 4'h8;
      {len, keys, mode, lvl, wen, pin, duty} = '0;
      keys = 18'h3_58D1;
      n_errors = 0;
      check_count = 0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      en = 1'b1;
      s_reset();
      s_order();
      s_wrong();
      s_six();
      s_off();
      s_pins();
      complete_run();
   end
endmodule
`default_nettype wire
